/* File: shared/cbd_defs.vh */
// Purpose: Constants for the character binary and decimal arithmetic unit
// Assumes: APB register map, one aligned 32-bit word per register
// Notes:   Function
// Function
// - Binary add sets zero and no-overflow flags
// - Binary add drops carry past top bit
// - Subtract register from 1-16 char field
// - Subtract uses six unsigned data bits/char
// - Subtract adds two's complement; carry sets flag
// - Subtract zero flag from difference only
// - Quad word gets unsigned 24-bit sum
// - Quad carry clears no-overflow, no real overflow
// - Add immediate char to memory char
// - Char add ripples; carry out of low char clears flag
// - Multiply register two by multiplier into accumulator
// - Fresh multiply clears accumulator, accumulate keeps it
// - Multiplicand length from sentinel, zero length zero
// - Digit overflow sets decimal flag, requests interrupt
// - Product sign from operand signs, accumulator assumed
// - Multiply destroys multiplier, keeps register two
// - Fresh updates zero and minus; accumulate minus
// - Divide accumulator by register two into quotient
// - Remainder keeps dividend sign, divisor unchanged
// - Shifted divisor below dividend sets decimal overflow
// - Divide sets zero from remainder, minus quotient
`ifndef CBD_DEFS_VH
`define CBD_DEFS_VH

// Register byte offsets
`define CBD_OFF_CTRL     8'h00
`define CBD_OFF_STATUS   8'h04
`define CBD_OFF_MEM0     8'h08
`define CBD_OFF_MEM1     8'h0C
`define CBD_OFF_MEM2     8'h10
`define CBD_OFF_AREG0    8'h14
`define CBD_OFF_AREG1    8'h18
`define CBD_OFF_AREG2    8'h1C
`define CBD_OFF_QUAD     8'h20
`define CBD_OFF_ACC_LO   8'h24
`define CBD_OFF_ACC_HI   8'h28
`define CBD_OFF_ACC_SGN  8'h2C
`define CBD_OFF_R2_LO    8'h30
`define CBD_OFF_R2_HI    8'h34
`define CBD_OFF_R2_INFO  8'h38
`define CBD_OFF_MLR      8'h3C
`define CBD_OFF_MLR_SGN  8'h40

// Opcodes in control bits [2:0]
`define CBD_OP_BADD      3'h0
`define CBD_OP_BSUB      3'h1
`define CBD_OP_QUAD      3'h2
`define CBD_OP_ACHR      3'h3
`define CBD_OP_MFRESH    3'h4
`define CBD_OP_MACC      3'h5
`define CBD_OP_DIV       3'h6

// Control field positions
`define CBD_CTRL_OP      2:0
`define CBD_CTRL_LEN     12:8
`define CBD_CTRL_IMM     21:16
`define CBD_INFO_LEN     7:4

// Limits and reset values
`define CBD_MAX_CHARS    5'h10
`define CBD_MAX_DIGITS   5'h08
`define CBD_DIG_MAX      5'h09
`define CBD_DIG_ADJ      5'h06
`define CBD_NBO_RST      1'b1

`endif

/* File: core/cbd_arith_unit.v */
// Purpose: Binary and decimal arithmetic unit behind an APB slave
// Assumes: Single pclk domain, operands loaded over APB before start
// Notes:   Decimal values are packed BCD, up to sixteen digits (multiplier eight), sign apart
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "cbd_defs.vh"

module cbd_arith_unit #(
  parameter AW = 8
) (
  input  wire          pclk,
  input  wire          presetn,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [AW-1:0] paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output wire          pready,
  output reg           pslverr,
  output reg           overflow_request
);

  localparam ST_IDLE   = 3'h0;
  localparam ST_MSHIFT = 3'h1;
  localparam ST_MADD   = 3'h2;
  localparam ST_MFIN   = 3'h3;
  localparam ST_DSUB   = 3'h4;

  ////////////////////////////////////////////////////////////////////////
  // Packed BCD helpers
  ////////////////////////////////////////////////////////////////////////

  // Sixteen-digit BCD add with carry in, carry out in bit 64
  function [64:0] bcd_add;
    input [63:0] a;
    input [63:0] b;
    input        ci;
    reg   [4:0]  s;
    reg          c;
    integer      k;
    begin
      c = ci;
      bcd_add = 65'h0;
      for (k = 0; k < 16; k = k + 1) begin
        s = {1'b0, a[4*k +: 4]} + {1'b0, b[4*k +: 4]} + {4'h0, c};
        if (s > `CBD_DIG_MAX) begin
          s = s + `CBD_DIG_ADJ;
          c = 1'b1;
        end else begin
          c = 1'b0;
        end
        bcd_add[4*k +: 4] = s[3:0];
      end
      bcd_add[64] = c;
    end
  endfunction

  // Nines complement per digit, for ten's complement subtract
  function [63:0] bcd_nines;
    input [63:0] a;
    integer      k;
    begin
      bcd_nines = 64'h0;
      for (k = 0; k < 16; k = k + 1) begin
        bcd_nines[4*k +: 4] = 4'h9 - a[4*k +: 4];
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State
  ////////////////////////////////////////////////////////////////////////

  reg  [2:0]  state_q;
  reg  [2:0]  op_q;
  reg  [95:0] mem_q;
  reg  [95:0] areg_q;
  reg  [23:0] quad_q;
  reg  [63:0] acc_q;
  reg         acc_sgn_q;
  reg  [63:0] r2_q;
  reg         r2_sgn_q;
  reg  [3:0]  r2_len_q;
  reg  [31:0] mlr_q;
  reg         mlr_sgn_q;
  reg  [63:0] work_q;
  reg  [31:0] quo_q;
  reg  [3:0]  rep_q;
  reg  [2:0]  idx_q;
  reg         zero_q;
  reg         minus_q;
  reg         nbo_q;
  reg         dovf_q;
  reg         movf_q;

  wire busy = (state_q != ST_IDLE);
  wire wr_acc = psel & penable & pwrite;
  wire rd_setup = psel & ~penable;

  // Zero-wait slave; read data was captured in the setup cycle
  assign pready = 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // Operand length decode
  ////////////////////////////////////////////////////////////////////////

  wire [4:0] len_f = pwdata[`CBD_CTRL_LEN];
  wire [4:0] nchar = (len_f == 5'h0 || len_f > `CBD_MAX_CHARS) ?
                     `CBD_MAX_CHARS : len_f;
  wire [4:0] ndig  = (len_f == 5'h0 || len_f > `CBD_MAX_DIGITS) ?
                     `CBD_MAX_DIGITS : len_f;
  wire [6:0] nbits = {1'b0, nchar, 1'b0} + {nchar, 2'b00}; // 2L + 4L
  wire [6:0] dbits = {1'b0, r2_len_q, 2'b00};
  wire [95:0] cmask;
  wire [63:0] dmask;

  // Character mask of 6L bits and multiplicand mask from the sentinel
  genvar gi;
  generate
    for (gi = 0; gi < 96; gi = gi + 1) begin : g_mask
      assign cmask[gi] = (gi < nbits);
      if (gi < 64) begin : g_dig
        assign dmask[gi] = (gi < dbits);
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Single-cycle binary datapaths
  ////////////////////////////////////////////////////////////////////////

  wire [96:0] badd  = {1'b0, mem_q & cmask} + {1'b0, areg_q & cmask};
  wire [96:0] bsub  = {1'b0, mem_q & cmask} + {1'b0, ~areg_q & cmask}
                      + 97'h1;
  wire [24:0] qsum  = {1'b0, quad_q} + {1'b0, mem_q[23:0]};
  wire [96:0] csum  = {1'b0, mem_q & cmask}
                      + {91'h0, pwdata[`CBD_CTRL_IMM]};
  wire [6:0]  c0sum = {1'b0, mem_q[5:0]} + {1'b0, pwdata[`CBD_CTRL_IMM]};
  wire        badd_c = badd[nbits];
  wire        bsub_c = bsub[nbits];
  wire [95:0] badd_r = badd[95:0] & cmask;
  wire [95:0] bsub_r = bsub[95:0] & cmask;

  ////////////////////////////////////////////////////////////////////////
  // Decimal datapaths
  ////////////////////////////////////////////////////////////////////////

  wire [63:0] mcand  = r2_q & dmask;
  wire [64:0] madd   = bcd_add(work_q, mcand, 1'b0);
  wire [64:0] mfin   = bcd_add(acc_q, work_q, 1'b0);
  wire [95:0] dshift = {32'h0, mcand} << {idx_q, 2'b00};
  wire [95:0] dtop   = {32'h0, mcand} << {ndig[3:0], 2'b00};
  wire        dge    = ({32'h0, work_q} >= dshift);
  wire [64:0] dsub   = bcd_add(work_q, bcd_nines(dshift[63:0]), 1'b1);
  wire        psign  = r2_sgn_q ^ mlr_sgn_q;

  ////////////////////////////////////////////////////////////////////////
  // Register file, sequencer and flags
  ////////////////////////////////////////////////////////////////////////

  // All architectural state lives in one process so each has one driver
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q          <= ST_IDLE;
      op_q             <= 3'h0;
      mem_q            <= 96'h0;
      areg_q           <= 96'h0;
      quad_q           <= 24'h0;
      acc_q            <= 64'h0;
      acc_sgn_q        <= 1'b0;
      r2_q             <= 64'h0;
      r2_sgn_q         <= 1'b0;
      r2_len_q         <= 4'h0;
      mlr_q            <= 32'h0;
      mlr_sgn_q        <= 1'b0;
      work_q           <= 64'h0;
      quo_q            <= 32'h0;
      rep_q            <= 4'h0;
      idx_q            <= 3'h0;
      zero_q           <= 1'b0;
      minus_q          <= 1'b0;
      nbo_q            <= `CBD_NBO_RST;
      dovf_q           <= 1'b0;
      movf_q           <= 1'b0;
      overflow_request <= 1'b0;
    end else begin
      overflow_request <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          // Operand writes are accepted only while idle
          if (wr_acc) begin
            case (paddr)
              `CBD_OFF_MEM0:    mem_q[31:0]  <= pwdata;
              `CBD_OFF_MEM1:    mem_q[63:32] <= pwdata;
              `CBD_OFF_MEM2:    mem_q[95:64] <= pwdata;
              `CBD_OFF_AREG0:   areg_q[31:0]  <= pwdata;
              `CBD_OFF_AREG1:   areg_q[63:32] <= pwdata;
              `CBD_OFF_AREG2:   areg_q[95:64] <= pwdata;
              `CBD_OFF_QUAD:    quad_q <= pwdata[23:0];
              `CBD_OFF_ACC_LO:  acc_q[31:0]  <= pwdata;
              `CBD_OFF_ACC_HI:  acc_q[63:32] <= pwdata;
              `CBD_OFF_ACC_SGN: acc_sgn_q <= pwdata[0];
              `CBD_OFF_R2_LO:   r2_q[31:0]  <= pwdata;
              `CBD_OFF_R2_HI:   r2_q[63:32] <= pwdata;
              `CBD_OFF_R2_INFO: begin
                r2_sgn_q <= pwdata[0];
                r2_len_q <= pwdata[`CBD_INFO_LEN];
              end
              `CBD_OFF_MLR:     mlr_q <= pwdata;
              `CBD_OFF_MLR_SGN: mlr_sgn_q <= pwdata[0];
              `CBD_OFF_CTRL: begin
                op_q <= pwdata[`CBD_CTRL_OP];
                case (pwdata[`CBD_CTRL_OP])
                  `CBD_OP_BADD: begin
                    mem_q  <= (mem_q & ~cmask) | badd_r;
                    zero_q <= (badd_r == 96'h0);
                    nbo_q  <= ~badd_c;
                  end
                  `CBD_OP_BSUB: begin
                    // Register operand is only read, never written
                    mem_q  <= (mem_q & ~cmask) | bsub_r;
                    zero_q <= (bsub_r == 96'h0);
                    nbo_q  <= bsub_c;
                  end
                  `CBD_OP_QUAD: begin
                    quad_q <= qsum[23:0];
                    nbo_q  <= ~qsum[24];
                  end
                  `CBD_OP_ACHR: begin
                    mem_q <= (mem_q & ~cmask) | (csum[95:0] & cmask);
                    nbo_q <= ~c0sum[6];
                  end
                  `CBD_OP_MFRESH, `CBD_OP_MACC: begin
                    // Clear of the accumulator is deferred to the final add
                    work_q  <= 64'h0;
                    movf_q  <= 1'b0;
                    idx_q   <= ndig[2:0] - 3'h1;
                    state_q <= ST_MSHIFT;
                  end
                  `CBD_OP_DIV: begin
                    if (dtop < {32'h0, acc_q}) begin
                      dovf_q <= 1'b1;
                      overflow_request <= 1'b1;
                    end else begin
                      work_q  <= acc_q;
                      quo_q   <= 32'h0;
                      rep_q   <= 4'h0;
                      idx_q   <= ndig[2:0] - 3'h1;
                      state_q <= ST_DSUB;
                    end
                  end
                  default: begin
                  end
                endcase
              end
              default: begin
              end
            endcase
          end
        end
        ST_MSHIFT: begin
          // Digits lost off the top mean the length limit was broken
          if (work_q[63:60] != 4'h0) begin
            movf_q <= 1'b1;
          end
          work_q  <= {work_q[59:0], 4'h0};
          rep_q   <= mlr_q[{idx_q, 2'b00} +: 4];
          state_q <= ST_MADD;
        end
        ST_MADD: begin
          // One multiplicand add per cycle per unit of the digit
          if (rep_q != 4'h0) begin
            work_q <= madd[63:0];
            rep_q  <= rep_q - 4'h1;
            if (madd[64]) begin
              movf_q <= 1'b1;
            end
          end else if (idx_q == 3'h0) begin
            state_q <= ST_MFIN;
          end else begin
            idx_q   <= idx_q - 3'h1;
            state_q <= ST_MSHIFT;
          end
        end
        ST_MFIN: begin
          // One request per instruction, however many digits were lost
          if (movf_q || (op_q != `CBD_OP_MFRESH && mfin[64])) begin
            dovf_q <= 1'b1;
            overflow_request <= 1'b1;
          end
          if (op_q == `CBD_OP_MFRESH) begin
            acc_q  <= work_q;
            zero_q <= (work_q == 64'h0);
          end else begin
            acc_q <= mfin[63:0];
          end
          acc_sgn_q <= psign;
          minus_q   <= psign;
          mlr_q     <= 32'h0;
          state_q   <= ST_IDLE;
        end
        ST_DSUB: begin
          // Restoring divide, one subtract or digit step per cycle
          if (dge) begin
            work_q <= dsub[63:0];
            rep_q  <= rep_q + 4'h1;
          end else begin
            quo_q <= {quo_q[27:0], rep_q};
            rep_q <= 4'h0;
            if (idx_q == 3'h0) begin
              mlr_q     <= {quo_q[27:0], rep_q};
              mlr_sgn_q <= acc_sgn_q ^ r2_sgn_q;
              acc_q     <= work_q;
              zero_q    <= (work_q == 64'h0);
              minus_q   <= acc_sgn_q ^ r2_sgn_q;
              state_q   <= ST_IDLE;
            end else begin
              idx_q <= idx_q - 3'h1;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB read path
  ////////////////////////////////////////////////////////////////////////

  // Data and error captured in setup so they stand through access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (rd_setup) begin
      pslverr <= 1'b0;
      case (paddr)
        `CBD_OFF_CTRL:    prdata <= {29'h0, op_q};
        `CBD_OFF_STATUS:  prdata <= {27'h0, busy, dovf_q, nbo_q, minus_q,
                                     zero_q};
        `CBD_OFF_MEM0:    prdata <= mem_q[31:0];
        `CBD_OFF_MEM1:    prdata <= mem_q[63:32];
        `CBD_OFF_MEM2:    prdata <= mem_q[95:64];
        `CBD_OFF_AREG0:   prdata <= areg_q[31:0];
        `CBD_OFF_AREG1:   prdata <= areg_q[63:32];
        `CBD_OFF_AREG2:   prdata <= areg_q[95:64];
        `CBD_OFF_QUAD:    prdata <= {8'h0, quad_q};
        `CBD_OFF_ACC_LO:  prdata <= acc_q[31:0];
        `CBD_OFF_ACC_HI:  prdata <= acc_q[63:32];
        `CBD_OFF_ACC_SGN: prdata <= {31'h0, acc_sgn_q};
        `CBD_OFF_R2_LO:   prdata <= r2_q[31:0];
        `CBD_OFF_R2_HI:   prdata <= r2_q[63:32];
        `CBD_OFF_R2_INFO: prdata <= {24'h0, r2_len_q, 3'h0, r2_sgn_q};
        `CBD_OFF_MLR:     prdata <= mlr_q;
        `CBD_OFF_MLR_SGN: prdata <= {31'h0, mlr_sgn_q};
        default: begin
          prdata  <= 32'h0;
          pslverr <= 1'b1;
        end
      endcase
    end
  end

endmodule

/* File: verification/cbd_arith_unit_properties.sv */
// Purpose: Port checks for the arithmetic unit slave
// Assumes: Zero wait APB, aligned byte addresses
// Notes:   Bound onto every cbd_arith_unit
`timescale 1ns/1ps
module cbd_chk #(
  parameter AW = 8
) (
  input wire          pclk,
  input wire          presetn,
  input wire          psel,
  input wire          penable,
  input wire          pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0]   pwdata,
  input wire [31:0]   prdata,
  input wire          pready,
  input wire          pslverr,
  input wire          overflow_request
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////
  // Overflow event is one pulse, never a level
  a_ovf_one_pulse:
    assert property (overflow_request |=> !overflow_request)
    else $error("overflow request longer than one cycle");
  // Nothing pending right after reset
  a_reset_quiet:
    assert property ($rose(presetn) |-> !pslverr && !overflow_request)
    else $error("error or overflow just after reset");
  // Zero wait slave
  a_ready_high: assert property (pready)
    else $error("pready low");
  // Aligned words are in error only above the map
  a_err_map: assert property (psel && penable && paddr[1:0] == 2'b00
    |-> pslverr == (paddr > 8'h40))
    else $error("slave error does not match address map");
  // Unmapped reads return zero
  a_unmapped_zero: assert property (psel && penable && !pwrite
    && paddr == 8'h44 |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  // Answer stands past the access edge
  a_rdata_holds:
    assert property (psel && penable |=> $stable(prdata))
    else $error("read data moved after access");
  a_err_holds:
    assert property (psel && penable |=> $stable(pslverr))
    else $error("slave error moved after access");
  // Accesses to the flag word never error
  a_status_ok:
    assert property (psel ##1 psel && penable && paddr == 8'h04
    |-> !pslverr && $past(psel))
    else $error("status access flagged as error");
endmodule

bind cbd_arith_unit cbd_chk #(.AW(AW)) u_chk (
  .pclk            (pclk),
  .presetn         (presetn),
  .psel            (psel),
  .penable         (penable),
  .pwrite          (pwrite),
  .paddr           (paddr),
  .pwdata          (pwdata),
  .prdata          (prdata),
  .pready          (pready),
  .pslverr         (pslverr),
  .overflow_request(overflow_request)
);

/* File: verification/cbd_seq_model.sv */
// Purpose: Sequencer side model driving the APB register bus
// Assumes: Requests start right after a rising edge
// Notes:   Waits for pready under a bounded count
`timescale 1ns/1ps
module cbd_seq_model (
  input  wire         pclk,
  output logic        psel,
  output logic        penable,
  output logic        pwrite,
  output logic [7:0]  paddr,
  output logic [31:0] pwdata,
  input  wire         pready,
  input  wire  [31:0] prdata,
  input  wire         pslverr
);
  int to_cnt = 0;

  ////////////////////////////////////////////////////////////////////////
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // One transfer; request held until pready is seen high
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rq,
                      output logic er);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      to_cnt++;
      tb.summarize();
    end
    rq = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~wd;  // Stale data must not look valid
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic        e;
    xfer(1'b1, a, d, x, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic e);
    xfer(1'b0, a, 32'h0000_0000, d, e);
  endtask
endmodule

/* File: verification/tb.sv */
// Purpose: Self-checking bench for the arithmetic unit
// Assumes: Operands loaded over APB, busy polled after each start
// Notes:   Expected values worked by hand from operand values
`timescale 1ns/1ps
`include "cbd_defs.vh"
module tb;
  logic        pclk;
  logic        presetn;
  wire         psel, penable, pwrite, pready, pslverr, overflow_request;
  wire  [7:0]  paddr;
  wire  [31:0] pwdata, prdata;
  int          fail_count = 0;
  int          compares = 0;
  int          pulses = 0;
  localparam logic [7:0] ST = `CBD_OFF_STATUS, M0 = `CBD_OFF_MEM0;
  localparam logic [7:0] A0 = `CBD_OFF_AREG0, QD = `CBD_OFF_QUAD;
  localparam logic [7:0] AL = `CBD_OFF_ACC_LO, AS = `CBD_OFF_ACC_SGN;
  localparam logic [7:0] RL = `CBD_OFF_R2_LO, RI = `CBD_OFF_R2_INFO;
  localparam logic [7:0] ML = `CBD_OFF_MLR, MS = `CBD_OFF_MLR_SGN;

  cbd_arith_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .overflow_request(overflow_request));
  cbd_seq_model seq (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr));

  ////////////////////////////////////////////////////////////////////////
  // 100 MHz clock and overflow pulse count
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) if (overflow_request === 1'b1) pulses <= pulses + 1;

  task automatic chk(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic        er;
    seq.rd(a, d, er);
    chk($sformatf("reg %h", a), e, d);
  endtask

  // Start an operation, then poll busy with a bound
  task automatic run(input logic [31:0] c);
    logic [31:0] d;
    logic        er;
    int          n;
    seq.wr(`CBD_OFF_CTRL, c);
    d = 32'h0000_0010;
    n = 0;
    while (d[4] !== 1'b0 && n < 300) begin
      seq.rd(ST, d, er);
      n++;
    end
    if (n >= 300) begin
      chk("busy", 32'h0000_0000, d);
      summarize();
    end
  endtask

  // Two operand loads, run, result word and flag word
  task automatic op(input logic [7:0] a1, input logic [31:0] d1,
    input logic [7:0] a2, input logic [31:0] d2, input logic [31:0] c,
    input logic [7:0] ra, input logic [31:0] re, input logic [31:0] st);
    seq.wr(a1, d1);
    seq.wr(a2, d2);
    run(c);
    rc(ra, re);
    rc(ST, st);
  endtask

  task automatic summarize();
    fail_count += seq.to_cnt;
    if (fail_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0] d;
    logic        er;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rc(ST, 32'h0000_0004);
    seq.rd(8'h44, d, er);
    chk("unmapped error", 32'h0000_0001, {31'h0, er});
    seq.wr(ST, 32'h0000_001F);
    rc(ST, 32'h0000_0004);
    // Binary add, plain then carry off the top
    op(A0, 32'h0000_01CA, M0, 32'h0000_0AC7, 32'h0000_0200,
       M0, 32'h0000_0C91, 32'h0000_0004);
    op(A0, 32'h0000_0001, M0, 32'h0000_07FF, 32'h0000_0100,
       M0, 32'h0000_07C0, 32'h0000_0001);
    // Subtract: carry, no carry, zero
    op(A0, 32'h0000_9206, M0, 32'h0000_B265, 32'h0000_0301,
       M0, 32'h0000_205F, 32'h0000_0004);
    rc(A0, 32'h0000_9206);
    op(A0, 32'h0000_0002, M0, 32'h0000_0001, 32'h0000_0101,
       M0, 32'h0000_003F, 32'h0000_0000);
    op(A0, 32'h0000_0005, M0, 32'h0000_0005, 32'h0000_0101,
       M0, 32'h0000_0000, 32'h0000_0005);
    // Quad word; zero flag left alone
    op(QD, 32'h00FF_FFFF, M0, 32'h0000_0001, 32'h0000_0002,
       QD, 32'h0000_0000, 32'h0000_0001);
    op(QD, 32'h0000_0010, M0, 32'h0000_0020, 32'h0000_0002,
       QD, 32'h0000_0030, 32'h0000_0005);
    // Immediate character, rippling and not
    op(M0, 32'h0000_00BF, M0, 32'h0000_00BF, 32'h0001_0203,
       M0, 32'h0000_00C0, 32'h0000_0001);
    op(M0, 32'h0000_0004, M0, 32'h0000_0004, 32'h0010_0103,
       M0, 32'h0000_0014, 32'h0000_0005);
    // Divide a negative dividend, padded to fit, then one that overflows
    seq.wr(RI, 32'h0000_0020);
    seq.wr(AS, 32'h0000_0001);
    op(RL, 32'h0000_0017, AL, 32'h0000_7230, 32'h0000_0406,
       ML, 32'h0000_0425, 32'h0000_0006);
    rc(AL, 32'h0000_0005);
    rc(AS, 32'h0000_0001);
    rc(RL, 32'h0000_0017);
    seq.wr(RI, 32'h0000_0010);
    seq.wr(AS, 32'h0000_0000);
    op(RL, 32'h0000_0001, AL, 32'h0000_9999, 32'h0000_0306,
       AL, 32'h0000_9999, 32'h0000_000E);
    chk("pulses", 32'd1, pulses);
    // Multiply fresh, accumulate, zero multiplicand
    seq.wr(RI, 32'h0000_0050);
    seq.wr(MS, 32'h0000_0000);
    seq.wr(ML, 32'h0000_0182);
    op(RL, 32'h0001_3256, AL, 32'h0000_2054, 32'h0000_0304,
       AL, 32'h0241_2592, 32'h0000_000C);
    rc(RL, 32'h0001_3256);
    rc(ML, 32'h0000_0000);
    seq.wr(RI, 32'h0000_0051);
    op(ML, 32'h0000_0182, AL, 32'h0000_2054, 32'h0000_0305,
       AL, 32'h0241_4646, 32'h0000_000E);
    rc(AS, 32'h0000_0001);
    seq.wr(RI, 32'h0000_0000);
    op(ML, 32'h0000_0182, AL, 32'h0000_2054, 32'h0000_0304,
       AL, 32'h0000_0000, 32'h0000_000D);
    // Too many digits overflows the product
    seq.wr(`CBD_OFF_R2_HI, 32'h0999_9999);
    seq.wr(RI, 32'h0000_00F0);
    seq.wr(RL, 32'h9999_9999);
    seq.wr(ML, 32'h9999_9999);
    run(32'h0000_0804);
    chk("pulses", 32'd2, pulses);
    rc(RL, 32'h9999_9999);
    summarize();
  end
endmodule
